// file: include/mtc_pkg.sv
// constants for the machine trap csr unit: csr addresses, field positions,
// cause codes and vector modes. assumes a 12-bit csr address space.
package mtc_pkg;

    // csr addresses
    localparam logic [11:0] ADDR_STATUS  = 12'h300;
    localparam logic [11:0] ADDR_IE      = 12'h304;
    localparam logic [11:0] ADDR_TVEC    = 12'h305;
    localparam logic [11:0] ADDR_TVT     = 12'h307;
    localparam logic [11:0] ADDR_SCRATCH = 12'h340;
    localparam logic [11:0] ADDR_CAUSE   = 12'h342;
    localparam logic [11:0] ADDR_IP      = 12'h344;
    localparam logic [11:0] ADDR_NXTI    = 12'h345;
    localparam logic [11:0] ADDR_ISTAT   = 12'h346;

    // status fields
    localparam int ST_MIE      = 3;
    localparam int ST_MPIE     = 7;
    localparam int ST_MPP_LO   = 11;
    // enable / pending bit positions
    localparam int BIT_SW      = 3;
    localparam int BIT_TMR     = 7;
    localparam int BIT_EXT     = 11;
    // cause fields
    localparam int CA_IRQ      = 31;
    localparam int CA_HV       = 30;
    localparam int CA_MPP_LO   = 28;
    localparam int CA_MPIE     = 27;
    localparam int CA_PIL_LO   = 16;
    localparam int CODE_W      = 10;
    // level field of the interrupt status register, table and vector base low bits
    localparam int LVL_LO      = 24;
    localparam int TVT_LO      = 6;
    localparam int TVEC_LO     = 2;

    // cause codes
    localparam logic [9:0] IRQ_SW      = 10'h003;
    localparam logic [9:0] IRQ_TMR     = 10'h007;
    localparam logic [9:0] IRQ_EXT     = 10'h00B;
    localparam logic [9:0] IRQ_LCLSW   = 10'h00C;
    localparam logic [9:0] IRQ_LOCAL0  = 10'h010;
    localparam logic [9:0] EXC_IMIS    = 10'h000;
    localparam logic [9:0] EXC_IFLT    = 10'h001;
    localparam logic [9:0] EXC_ILL     = 10'h002;
    localparam logic [9:0] EXC_BRK     = 10'h003;
    localparam logic [9:0] EXC_LMIS    = 10'h004;
    localparam logic [9:0] EXC_LFLT    = 10'h005;
    localparam logic [9:0] EXC_SMIS    = 10'h006;
    localparam logic [9:0] EXC_SFLT    = 10'h007;
    localparam logic [9:0] EXC_ECALL   = 10'h00B;

    // vector modes
    typedef enum logic [1:0] {
        MTC_DIRECT   = 2'b00,
        MTC_VECTORED = 2'b01,
        MTC_LC_DIR   = 2'b10,
        MTC_LC_VEC   = 2'b11
    } mtc_mode_t;

    // vectoring sequence states
    typedef enum logic [1:0] {
        MTC_IDLE  = 2'b00,
        MTC_FETCH = 2'b01,
        MTC_JUMP  = 2'b10
    } mtc_state_t;

    localparam logic [1:0]  PRIV_M     = 2'h3;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

endpackage : mtc_pkg

// file: core/mtc_unit.sv
// machine trap csr unit: status, enables, pendings, vector base and
// table, cause, next-interrupt, active level and scratch.
// assumes the pipeline issues one csr access or trap event per cycle and
// the local controller arbitrates its sources, presenting its winner.
// Behaviour
// - global enable bit 3 gates interrupt entry
// - legacy modes need global and cause enable
// - enables at bits 11, 7, 3
// - local modes read enables zero
// - pendings read-only at bits 11, 7, 3
// - local modes read pendings zero
// - previous fields mirrored into cause in local modes
// - mode 0 traps go to base
// - mode 1 interrupts to base plus 4x code
// - mode 2 traps go to base
// - mode 3 interrupts via table entry
// - table fetch sets vectoring flag, a successful jump clears it
// - legacy modes support three causes only
// - cause written on every trap
// - extended cause fields in local modes
// - interrupt cause code encoding
// - exception cause code encoding
// - table base bits 31:6, low zero
// - next-interrupt needs level above saved level
// - next-interrupt reads zero or entry address
// - next-interrupt write updates status, code, level
// - active level at bits 31:24
// - entry saves enable, level, privilege, pc
// - return restores privilege and enable, and level in local modes
// - ties go to largest interrupt number
`timescale 1ns/1ps

module mtc_unit #(
    parameter int XLEN = 32
) (
    // clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              clk_en,
    // csr access from the pipeline
    input  wire logic              csr_req,
    input  wire logic [11:0]       csr_addr,
    input  wire logic [1:0]        csr_op,      // 1 write, 2 set, 3 clear, 0 read
    input  wire logic [XLEN-1:0]   csr_wdata,
    output logic      [XLEN-1:0]   csr_rdata,
    // trap events from the pipeline
    input  wire logic              exc_valid,
    input  wire logic [9:0]        exc_code,
    input  wire logic [XLEN-1:0]   trap_pc,
    input  wire logic              mret,
    input  wire logic [1:0]        cur_priv,
    // legacy interrupt sources
    input  wire logic              software_irq_pending,
    input  wire logic              timer_irq_pending,
    input  wire logic              external_irq_pending,
    // local controller winner: already enabled, highest level and id
    input  wire logic              lc_valid,
    input  wire logic [9:0]        lc_code,
    input  wire logic [7:0]        lc_level,
    // table fetch port
    output logic                   fetch_req,
    output logic      [XLEN-1:0]   fetch_addr,
    input  wire logic              fetch_done,
    input  wire logic              fetch_err,
    input  wire logic [XLEN-1:0]   fetch_data,
    // redirect to the pipeline
    output logic                   redirect,
    output logic      [XLEN-1:0]   redirect_pc,
    output logic      [1:0]        priv_out,
    output logic      [XLEN-1:0]   epc_out,
    output logic                   irq_taken
);

    // architectural state
    logic             global_irq_enable;
    logic             prev_irq_enable;
    logic [1:0]       prev_priv;
    logic             software_irq_enable;
    logic             timer_irq_enable;
    logic             external_irq_enable;
    logic [XLEN-1:0]  trap_vector_base;
    logic [XLEN-1:0]  vector_table_base;
    logic [XLEN-1:0]  trap_scratch;
    logic             cause_irq;
    logic             hw_vectoring_flag;
    logic [7:0]       previous_irq_level;
    logic [9:0]       cause_code;
    logic [7:0]       active_level;
    logic [XLEN-1:0]  epc;
    mtc_pkg::mtc_state_t state;

    // combinational views
    mtc_pkg::mtc_mode_t mode;
    logic             lc_mode;
    logic [XLEN-1:0]  status_view;
    logic [XLEN-1:0]  ie_view;
    logic [XLEN-1:0]  ip_view;
    logic [XLEN-1:0]  cause_view;
    logic [XLEN-1:0]  istat_view;
    logic [XLEN-1:0]  nxti_view;
    logic             nxti_hit;
    logic             irq_go;
    logic [9:0]       irq_code;
    logic             busy;
    logic             wr_any;
    logic [XLEN-1:0]  next_word;
    logic [XLEN-1:0]  cur_word;
    logic [XLEN-1:0]  base_addr;
    logic [XLEN-1:0]  entry_addr;

    // applies write, set or clear to an old value
    function automatic logic [XLEN-1:0] mtc_apply(input logic [1:0] op,
                                                 input logic [XLEN-1:0] old,
                                                 input logic [XLEN-1:0] val);
        case (op)
            2'h1:    return val;
            2'h2:    return old | val;
            2'h3:    return old & ~val;
            default: return old;
        endcase
    endfunction : mtc_apply

    // table entry address for a code, shared by dispatch and next-interrupt
    function automatic logic [XLEN-1:0] mtc_entry(input logic [XLEN-1:0] tbl,
                                                 input logic [9:0] code);
        return tbl + XLEN'({code, 2'b00});
    endfunction : mtc_entry

    assign mode    = mtc_pkg::mtc_mode_t'(trap_vector_base[1:0]);
    assign lc_mode = trap_vector_base[1];
    assign busy    = (state != mtc_pkg::MTC_IDLE);
    assign base_addr = {trap_vector_base[XLEN-1:mtc_pkg::TVEC_LO], 2'b00};

    // legacy arbitration, largest number first among enabled pendings
    always_comb
    begin
        irq_code = mtc_pkg::IRQ_SW;
        irq_go   = 1'b0;
        if (lc_mode)
        begin
            irq_go   = lc_valid && (lc_level > active_level);
            irq_code = lc_code;
        end
        else if (external_irq_pending && external_irq_enable)
        begin
            irq_go   = 1'b1;
            irq_code = mtc_pkg::IRQ_EXT;
        end
        else if (timer_irq_pending && timer_irq_enable)
        begin
            irq_go   = 1'b1;
            irq_code = mtc_pkg::IRQ_TMR;
        end
        else if (software_irq_pending && software_irq_enable)
        begin
            irq_go   = 1'b1;
            irq_code = mtc_pkg::IRQ_SW;
        end
        irq_go = irq_go && global_irq_enable && !busy && !exc_valid;
    end

    // register read views
    always_comb
    begin
        status_view = '0;
        status_view[mtc_pkg::ST_MIE]  = global_irq_enable;
        status_view[mtc_pkg::ST_MPIE] = prev_irq_enable;
        status_view[mtc_pkg::ST_MPP_LO+1:mtc_pkg::ST_MPP_LO] = prev_priv;
        ie_view = '0;
        ip_view = '0;
        if (!lc_mode)
        begin
            ie_view[mtc_pkg::BIT_SW]  = software_irq_enable;
            ie_view[mtc_pkg::BIT_TMR] = timer_irq_enable;
            ie_view[mtc_pkg::BIT_EXT] = external_irq_enable;
            ip_view[mtc_pkg::BIT_SW]  = software_irq_pending;
            ip_view[mtc_pkg::BIT_TMR] = timer_irq_pending;
            ip_view[mtc_pkg::BIT_EXT] = external_irq_pending;
        end
        cause_view = '0;
        cause_view[mtc_pkg::CA_IRQ] = cause_irq;
        cause_view[mtc_pkg::CODE_W-1:0] = cause_code;
        if (lc_mode)
        begin
            cause_view[mtc_pkg::CA_HV] = hw_vectoring_flag;
            cause_view[mtc_pkg::CA_MPP_LO+1:mtc_pkg::CA_MPP_LO] = prev_priv;
            cause_view[mtc_pkg::CA_MPIE] = prev_irq_enable;
            cause_view[mtc_pkg::CA_PIL_LO+7:mtc_pkg::CA_PIL_LO] = previous_irq_level;
        end
        istat_view = '0;
        istat_view[mtc_pkg::LVL_LO+7:mtc_pkg::LVL_LO] = active_level;
    end

    // next-interrupt: only a winner above the saved level qualifies
    assign nxti_hit  = lc_mode && lc_valid && (lc_level > previous_irq_level);
    assign nxti_view = nxti_hit ? mtc_entry(vector_table_base, lc_code) : '0;
    assign entry_addr = mtc_entry(vector_table_base, irq_code);

    // read mux
    always_comb
    begin
        case (csr_addr)
            mtc_pkg::ADDR_STATUS:  cur_word = status_view;
            mtc_pkg::ADDR_IE:      cur_word = ie_view;
            mtc_pkg::ADDR_TVEC:    cur_word = trap_vector_base;
            mtc_pkg::ADDR_TVT:     cur_word = vector_table_base;
            mtc_pkg::ADDR_SCRATCH: cur_word = trap_scratch;
            mtc_pkg::ADDR_CAUSE:   cur_word = cause_view;
            mtc_pkg::ADDR_IP:      cur_word = ip_view;
            mtc_pkg::ADDR_NXTI:    cur_word = nxti_view;
            mtc_pkg::ADDR_ISTAT:   cur_word = istat_view;
            default:               cur_word = '0;
        endcase
        wr_any    = csr_req && (csr_op != 2'h0);
        // next-interrupt writes modify the status word
        next_word = mtc_apply(csr_op,
                              (csr_addr == mtc_pkg::ADDR_NXTI) ? status_view : cur_word,
                              csr_wdata);
    end

    // read data register
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            csr_rdata <= mtc_pkg::RESET_ZERO;
        else if (clk_en && csr_req)
            csr_rdata <= cur_word;
    end

    // simple software registers: enables, bases, scratch
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            software_irq_enable <= 1'b0;
            timer_irq_enable    <= 1'b0;
            external_irq_enable <= 1'b0;
            trap_vector_base    <= mtc_pkg::RESET_ZERO;
            vector_table_base   <= mtc_pkg::RESET_ZERO;
            trap_scratch        <= mtc_pkg::RESET_ZERO;
        end
        else if (clk_en && wr_any)
        begin
            case (csr_addr)
                mtc_pkg::ADDR_IE:
                begin
                    // writes ignored while the register is hardwired
                    if (!lc_mode)
                    begin
                        software_irq_enable <= next_word[mtc_pkg::BIT_SW];
                        timer_irq_enable    <= next_word[mtc_pkg::BIT_TMR];
                        external_irq_enable <= next_word[mtc_pkg::BIT_EXT];
                    end
                end
                // alignment of the base is software's duty
                mtc_pkg::ADDR_TVEC:    trap_vector_base <= next_word;
                mtc_pkg::ADDR_TVT:
                    vector_table_base <= {next_word[XLEN-1:mtc_pkg::TVT_LO],
                                          (mtc_pkg::TVT_LO)'(0)};
                mtc_pkg::ADDR_SCRATCH: trap_scratch <= next_word;
                default: ;
            endcase
        end
    end

    // status, cause and level: traps win over software writes
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            global_irq_enable  <= 1'b0;
            prev_irq_enable    <= 1'b0;
            prev_priv          <= mtc_pkg::PRIV_M;
            cause_irq          <= 1'b0;
            cause_code         <= '0;
            previous_irq_level <= '0;
            active_level       <= '0;
            priv_out           <= mtc_pkg::PRIV_M;
            epc_out            <= mtc_pkg::RESET_ZERO;
        end
        else if (clk_en)
        begin
            if (exc_valid || irq_go)
            begin
                prev_irq_enable    <= global_irq_enable;
                global_irq_enable  <= 1'b0;
                prev_priv          <= cur_priv;
                previous_irq_level <= active_level;
                epc_out            <= trap_pc;
                priv_out           <= mtc_pkg::PRIV_M;
                cause_irq          <= !exc_valid;
                cause_code         <= exc_valid ? exc_code : irq_code;
                if (!exc_valid && lc_mode)
                    active_level <= lc_level;
            end
            else if (mret)
            begin
                priv_out          <= prev_priv;
                global_irq_enable <= prev_irq_enable;
                prev_irq_enable   <= 1'b1;
                if (lc_mode)
                    active_level <= previous_irq_level;
            end
            else if (wr_any)
            begin
                case (csr_addr)
                    mtc_pkg::ADDR_STATUS:
                    begin
                        global_irq_enable <= next_word[mtc_pkg::ST_MIE];
                        prev_irq_enable   <= next_word[mtc_pkg::ST_MPIE];
                        prev_priv <= next_word[mtc_pkg::ST_MPP_LO+1:mtc_pkg::ST_MPP_LO];
                    end
                    mtc_pkg::ADDR_CAUSE:
                    begin
                        cause_irq  <= next_word[mtc_pkg::CA_IRQ];
                        cause_code <= next_word[mtc_pkg::CODE_W-1:0];
                        if (lc_mode)
                        begin
                            prev_priv <= next_word[mtc_pkg::CA_MPP_LO+1:mtc_pkg::CA_MPP_LO];
                            prev_irq_enable <= next_word[mtc_pkg::CA_MPIE];
                            previous_irq_level <=
                                next_word[mtc_pkg::CA_PIL_LO+7:mtc_pkg::CA_PIL_LO];
                        end
                    end
                    mtc_pkg::ADDR_NXTI:
                    begin
                        global_irq_enable <= next_word[mtc_pkg::ST_MIE];
                        prev_irq_enable   <= next_word[mtc_pkg::ST_MPIE];
                        if (nxti_hit)
                        begin
                            cause_code   <= lc_code;
                            active_level <= lc_level;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // dispatch and table fetch sequence
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state             <= mtc_pkg::MTC_IDLE;
            hw_vectoring_flag <= 1'b0;
            fetch_req         <= 1'b0;
            fetch_addr        <= mtc_pkg::RESET_ZERO;
            redirect          <= 1'b0;
            redirect_pc       <= mtc_pkg::RESET_ZERO;
            irq_taken         <= 1'b0;
        end
        else if (clk_en)
        begin
            redirect  <= 1'b0;
            irq_taken <= irq_go;
            case (state)
                mtc_pkg::MTC_IDLE:
                begin
                    if (exc_valid)
                    begin
                        redirect    <= 1'b1;
                        redirect_pc <= base_addr;
                    end
                    else if (irq_go)
                    begin
                        case (mode)
                            mtc_pkg::MTC_VECTORED:
                            begin
                                redirect    <= 1'b1;
                                redirect_pc <= base_addr + XLEN'({irq_code, 2'b00});
                            end
                            mtc_pkg::MTC_LC_VEC:
                            begin
                                hw_vectoring_flag <= 1'b1;
                                fetch_req         <= 1'b1;
                                fetch_addr        <= entry_addr;
                                state             <= mtc_pkg::MTC_FETCH;
                            end
                            default:
                            begin
                                redirect    <= 1'b1;
                                redirect_pc <= base_addr;
                            end
                        endcase
                    end
                    else if (mret)
                    begin
                        redirect    <= 1'b1;
                        redirect_pc <= epc_out;
                    end
                end
                mtc_pkg::MTC_FETCH:
                begin
                    if (fetch_done)
                    begin
                        fetch_req <= 1'b0;
                        // a failed fetch leaves the flag set for the handler
                        if (!fetch_err)
                        begin
                            redirect    <= 1'b1;
                            redirect_pc <= {fetch_data[XLEN-1:1], 1'b0};
                            state       <= mtc_pkg::MTC_JUMP;
                        end
                        else
                            state <= mtc_pkg::MTC_IDLE;
                    end
                end
                mtc_pkg::MTC_JUMP:
                begin
                    hw_vectoring_flag <= 1'b0;
                    state             <= mtc_pkg::MTC_IDLE;
                end
                default: state <= mtc_pkg::MTC_IDLE;
            endcase
        end
    end

endmodule : mtc_unit

// file: verification/mtc_unit_sva.sv
// port-level assertions for the machine trap csr unit
// assumes one core_clk domain, rstn async active low
`timescale 1ns/1ps
module mtc_unit_sva #(
    parameter int XLEN = 32
) (
    // clock and reset
    input wire logic            core_clk, rstn, clk_en,
    // pipeline events and answers
    input wire logic            exc_valid, mret, redirect, irq_taken,
    input wire logic [XLEN-1:0] trap_pc, redirect_pc, epc_out,
    input wire logic [1:0]      priv_out,
    // table fetch port
    input wire logic            fetch_req, fetch_done, fetch_err,
    input wire logic [XLEN-1:0] fetch_addr, fetch_data
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // exceptions redirect next cycle and beat a same-cycle interrupt
    AST_EXC_REDIR: assert property (exc_valid && clk_en |=> redirect && !irq_taken)
        else $error("exception gave no redirect");
    AST_EXC_SAVE: assert property (exc_valid && clk_en |=> epc_out == $past(trap_pc)
        && priv_out == 2'h3) else $error("trap entry state wrong");
    AST_MRET_PC: assert property (mret && !exc_valid && clk_en |=> redirect
        && redirect_pc == $past(epc_out)) else $error("return pc wrong");
    // fetch request must not wander while the far side works
    AST_FETCH_HOLD: assert property (fetch_req && !fetch_done |=> fetch_req
        && $stable(fetch_addr)) else $error("fetch request dropped early");
    AST_FETCH_ALIGN: assert property (fetch_req |-> fetch_addr[1:0] == 2'b00)
        else $error("fetch address unaligned");
    AST_FETCH_JUMP: assert property (fetch_req && fetch_done && !fetch_err && clk_en
        |=> redirect && redirect_pc == ($past(fetch_data) & ~XLEN'(1)))
        else $error("table jump wrong");
    AST_FETCH_ERR: assert property (fetch_req && fetch_done && fetch_err |=> !redirect[*3])
        else $error("redirect after fetch error");
    // entry clears the global enable, so no second entry right behind
    AST_IRQ_PULSE: assert property (irq_taken |=> !irq_taken)
        else $error("interrupt taken twice");
endmodule : mtc_unit_sva

bind mtc_unit mtc_unit_sva #(.XLEN(XLEN)) i_mtc_unit_sva (.core_clk, .rstn, .clk_en,
    .exc_valid, .mret, .redirect, .irq_taken, .trap_pc, .redirect_pc, .epc_out,
    .priv_out, .fetch_req, .fetch_done, .fetch_err, .fetch_addr, .fetch_data);

// file: verification/mtc_fetch_model.sv
// vector table memory answering the unit's fetch port
// answers after lag cycles; err_on makes the answer a fault
`timescale 1ns/1ps
module mtc_fetch_model (
    input  wire logic        core_clk, rstn, fetch_req, err_on,
    input  wire logic [3:0]  lag,
    input  wire logic [31:0] fetch_addr,
    output logic             fetch_done, fetch_err,
    output logic [31:0]      fetch_data
);
    logic [3:0] cnt;

    // one-cycle done pulse once the request has waited lag cycles
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 4'h0;
            fetch_done <= 1'b0;
        end
        else if (fetch_req && !fetch_done && cnt == lag)
        begin
            cnt <= 4'h0;
            fetch_done <= 1'b1;
        end
        else
        begin
            fetch_done <= 1'b0;
            cnt <= cnt + 4'(fetch_req && !fetch_done);
        end
    end
    // entry has bit 0 set so the jump must clear it; junk outside the answer
    assign fetch_data = fetch_done ? ~fetch_addr : {8{cnt}};
    assign fetch_err = fetch_done & err_on;
endmodule : mtc_fetch_model

// file: verification/mtc_unit_bench.sv
// self-checking bench for the machine trap csr unit
// assumes the fetch model on the table port; bench plays pipeline and sources
`timescale 1ns/1ps
module mtc_unit_bench;
    logic core_clk = 0, rstn = 0, csr_req = 0, exc_valid = 0, mret = 0, lc_valid = 0;
    logic err_on = 0, fetch_req, fetch_done, fetch_err, redirect, irq_taken;
    logic [1:0] csr_op = 0, priv_out;
    logic [2:0] pend = 0;
    logic [3:0] lag = 4'h3;
    logic [7:0] lc_level = 0;
    logic [9:0] exc_code = 0, lc_code = 0, code;
    logic [11:0] csr_addr = 0;
    logic [31:0] csr_wdata = 0, trap_pc = 0, csr_rdata, fetch_addr, fetch_data;
    logic [31:0] redirect_pc, epc_out, rd, base, tvt, seed = 32'h05C67808;
    logic [11:0] ra [10] = '{12'h300, 12'h304, 12'h305, 12'h307, 12'h340, 12'h342,
        12'h344, 12'h345, 12'h346, 12'h7C0};
    int n_fail = 0, samples_checked = 0;

    always #2 core_clk = ~core_clk;

    mtc_unit i_mtc_unit (.core_clk, .rstn, .clk_en(1'b1), .csr_req, .csr_addr, .csr_op,
        .csr_wdata, .csr_rdata, .exc_valid, .exc_code, .trap_pc, .mret, .cur_priv(2'h3),
        .software_irq_pending(pend[0]), .timer_irq_pending(pend[1]),
        .external_irq_pending(pend[2]), .lc_valid, .lc_code, .lc_level, .fetch_req,
        .fetch_addr, .fetch_done, .fetch_err, .fetch_data, .redirect, .redirect_pc,
        .priv_out, .epc_out, .irq_taken);
    mtc_fetch_model i_mtc_fetch_model (.core_clk, .rstn, .fetch_req, .err_on, .lag,
        .fetch_addr, .fetch_done, .fetch_err, .fetch_data);

    // xorshift source, fixed seed keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one access; read data lands on the taking edge, sampled 1 time unit after
    task automatic csr(input logic [1:0] op, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        csr_req <= 1'b1;
        csr_op <= op;
        csr_addr <= a;
        csr_wdata <= wd;
        @(posedge core_clk);
        csr_req <= 1'b0;
        #1 rd = csr_rdata;
    endtask : csr
    // a missing redirect masks the pc to zero and fails the compare
    task automatic wait_redir(input logic [31:0] exp);
        int k;
        #1 k = 0;
        while (redirect !== 1'b1 && k < 20)
        begin
            @(posedge core_clk);
            #1 k++;
        end
        cmp(redirect_pc & {32{redirect === 1'b1}}, exp);
    endtask : wait_redir
    task automatic do_mret();
        @(posedge core_clk);
        mret <= 1'b1;
        @(posedge core_clk);
        mret <= 1'b0;
        wait_redir(trap_pc);
    endtask : do_mret
    task automatic wait_fetch();
        repeat (20) if (fetch_req !== 1'b1) @(posedge core_clk) #1;
    endtask : wait_fetch
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // watchdog sized well above the few hundred cycles the tests need
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        // reset values, unknown address reads zero
        foreach (ra[i]) begin csr(0, ra[i], 0); cmp(rd, i == 0 ? 32'h1800 : 0); end
        csr(1, 12'h304, 32'hFFFFFFFF); csr(0, 12'h304, 0); cmp(rd, 32'h888);
        pend <= 3'b111;
        csr(1, 12'h344, 32'hFFFFFFFF); csr(0, 12'h344, 0); cmp(rd, 32'h888);
        cmp({31'h0, irq_taken}, 0);
        csr(1, 12'h307, 32'hFFFFFFFF); csr(0, 12'h307, 0); cmp(rd, 32'hFFFFFFC0);
        csr(1, 12'h346, 32'hFFFFFFFF); csr(0, 12'h346, 0); cmp(rd, 0);
        tvt = rnd();
        csr(1, 12'h340, tvt); csr(0, 12'h340, 0); cmp(rd, tvt);
        base = rnd() & 32'hFFFFFFC0;
        trap_pc <= rnd() & 32'hFFFFFFFC;
        csr(1, 12'h305, base | 32'h1);
        // all three pending: taken ext, timer, software in turn
        csr(2, 12'h300, 32'h8);
        for (int i = 0; i < 3; i++)
        begin
            code = 10'(11 - 4 * i);
            @(posedge core_clk);
            wait_redir(base + 4 * code);
            csr(0, 12'h342, 0); cmp(rd, 32'h80000000 | code);
            csr(0, 12'h300, 0); cmp(rd, 32'h1880);
            pend <= pend & ~(3'b100 >> i);
            do_mret();
        end
        csr(0, 12'h300, 0); cmp(rd & 32'h8, 32'h8);
        // every exception code goes to the base
        for (int i = 0; i < 9; i++)
        begin
            code = (i == 8) ? 10'h00B : 10'(i);
            @(posedge core_clk);
            exc_valid <= 1'b1;
            exc_code <= code;
            trap_pc <= rnd() & 32'hFFFFFFFC;
            @(posedge core_clk);
            exc_valid <= 1'b0;
            wait_redir(base);
            csr(0, 12'h342, 0); cmp(rd, {22'h0, code});
            do_mret();
        end
        // table vectoring through the fetch model
        tvt = rnd() & 32'hFFFFFFC0;
        csr(1, 12'h307, tvt);
        csr(1, 12'h305, base | 32'h3);
        csr(0, 12'h304, 0); cmp(rd, 0);
        pend <= 3'b010;
        csr(0, 12'h344, 0); cmp(rd, 0);
        code = 10'(16 + rnd() % 33);
        lc_code <= code;
        lc_level <= 8'h05;
        lc_valid <= 1'b1;
        wait_fetch();
        cmp(fetch_addr, tvt + 4 * code);
        lc_valid <= 1'b0;
        wait_redir(~(tvt + 4 * code) & ~32'h1);
        csr(0, 12'h342, 0); cmp(rd, 32'hB8000000 | code);
        csr(0, 12'h346, 0); cmp(rd, 32'h05000000);
        do_mret();
        // faulting table fetch leaves the vectoring flag up
        err_on <= 1'b1;
        lag <= 4'h0;
        lc_valid <= 1'b1;
        wait_fetch();
        lc_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        csr(0, 12'h342, 0); cmp(rd & 32'h40000000, 32'h40000000);
        report_and_stop();
    end
endmodule : mtc_unit_bench
